// File: osc_divider.sv
`timescale 1ns/1ps
`default_nettype none

// Makes the 32.768 kHz square wave as a toggling level from ref_clk.
module osc_divider #(
  parameter int HALF_CYCLES = 2
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic run,
  output var  logic wave
);

  localparam int CW = $clog2(HALF_CYCLES + 1);

  logic [CW-1:0] count;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      wave  <= 1'b0;
    end else if (!run) begin
      count <= '0;
      wave  <= 1'b0;
    end else if (count == CW'(HALF_CYCLES - 1)) begin
      count <= '0;
      wave  <= ~wave;
    end else begin
      count <= count + 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: rtc_event_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_flags_cfg.svh"

module rtc_event_status_flags
  import rtc_flags_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  input  wire bus_req_t       bus,
  input  wire logic [7:0]     ad_in,
  output logic [7:0]          ad_out,
  output logic                ad_oe,
  input  wire event_strobes_t events,
  input  wire logic           backup_valid,
  input  wire logic           sq_rate_wave,
  output logic                buffer_transfer_en,
  output logic [3:0]          rate_select,
  output logic                divider_run,
  output logic                irq_n,
  output logic                square_wave_out
);

  logic [7:0] addr;
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic       update_ended_flag;
  logic       alarm_flag;
  logic       periodic_flag;
  logic       irq_request_flag;
  logic       khz_out_enable;
  logic [7:0] next_rdata;
  logic       khz_wave;
  logic       status_unlocked;
  logic       status_read;
  logic       status_write;
  logic       irq_cond;
  logic       ctrl_a_write;
  logic       ctrl_b_write;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return bus.cs && (a == target);
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr <= 8'h00;
    end else if (bus.ale) begin
      addr <= ad_in;
    end
  end

  assign status_unlocked = (ctrl_a[`OSC_MSB:`OSC_LSB] == `OSC_RUN_UNLOCK);
  assign status_read     = bus.rd && hit(addr, `ADDR_EVENT_STATUS);
  assign status_write    = bus.wr && hit(addr, `ADDR_EVENT_STATUS) && status_unlocked;
  assign ctrl_a_write    = bus.wr && hit(addr, `ADDR_CTRL_A);
  assign ctrl_b_write    = bus.wr && hit(addr, `ADDR_CTRL_B);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a <= `CTRL_A_RESET;
    end else if (ctrl_a_write) begin
      ctrl_a <= {1'b0, bus.wdata[6:0]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_b <= `CTRL_B_RESET;
    end else begin
      if (ctrl_b_write) begin
        ctrl_b <= bus.wdata;
      end
      // Inhibit wins over a write of the update enable
      if ((ctrl_b_write && bus.wdata[`BIT_INHIBIT]) ||
          (ctrl_b[`BIT_INHIBIT] && !ctrl_b_write)) begin
        ctrl_b[`BIT_UPD_EN] <= 1'b0;
      end
    end
  end

  assign buffer_transfer_en = ~ctrl_b[`BIT_INHIBIT];
  assign rate_select        = ctrl_a[`RATE_MSB:`RATE_LSB];
  assign divider_run        = (ctrl_a[`OSC_MSB:`OSC_LSB] == `OSC_RUN) ||
                              status_unlocked;

  // Events win over the read clear so nothing is lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      update_ended_flag <= 1'b0;
    end else if (status_write) begin
      update_ended_flag <= bus.wdata[`BIT_UPD_FLAG] | events.update_done;
    end else begin
      update_ended_flag <= events.update_done |
                           (update_ended_flag & ~status_read);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_flag <= 1'b0;
    end else if (status_write) begin
      alarm_flag <= bus.wdata[`BIT_ALM_FLAG] | events.alarm_match;
    end else begin
      alarm_flag <= events.alarm_match |
                    (alarm_flag & ~status_read);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_flag <= 1'b0;
    end else if (status_write) begin
      periodic_flag <= bus.wdata[`BIT_PER_FLAG] | events.periodic_tick;
    end else begin
      periodic_flag <= events.periodic_tick |
                       (periodic_flag & ~status_read);
    end
  end

  // Condition is checked on the next values so a fresh event raises the request
  assign irq_cond =
      (ctrl_b[`BIT_ALM_EN] && (events.alarm_match   || (alarm_flag && !status_read))) ||
      (ctrl_b[`BIT_PER_EN] && (events.periodic_tick || (periodic_flag && !status_read))) ||
      (ctrl_b[`BIT_UPD_EN] && (events.update_done   || (update_ended_flag && !status_read)));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_request_flag <= 1'b0;
    end else if (status_write) begin
      irq_request_flag <= bus.wdata[`BIT_IRQF] | irq_cond;
    end else begin
      irq_request_flag <= irq_cond | (irq_request_flag & ~status_read);
    end
  end

  assign irq_n = ~irq_request_flag;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      khz_out_enable <= 1'b0;
    end else if (ctrl_a_write &&
                 bus.wdata[`OSC_MSB:`OSC_LSB] != `OSC_RUN_UNLOCK) begin
      khz_out_enable <= 1'b0;
    end else if (status_write) begin
      khz_out_enable <= bus.wdata[`BIT_KHZE];
    end
  end

  osc_divider #(
    .HALF_CYCLES(`OSC_HALF_CYCLES)
  ) u_osc (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .run     (khz_out_enable),
    .wave    (khz_wave)
  );

  // Square-wave disabled means held low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      square_wave_out <= 1'b0;
    end else if (!ctrl_b[`BIT_SQ_EN]) begin
      square_wave_out <= 1'b0;
    end else if (khz_out_enable) begin
      square_wave_out <= khz_wave;
    end else begin
      square_wave_out <= sq_rate_wave;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (addr)
      `ADDR_CTRL_A: next_rdata = ctrl_a;
      `ADDR_CTRL_B: next_rdata = ctrl_b;
      `ADDR_EVENT_STATUS: begin
        next_rdata[`BIT_IRQF] = irq_request_flag;
        next_rdata[`BIT_PER_FLAG] = periodic_flag;
        next_rdata[`BIT_ALM_FLAG] = alarm_flag;
        next_rdata[`BIT_UPD_FLAG] = update_ended_flag;
        next_rdata[`BIT_KHZE] = khz_out_enable;
      end
      `ADDR_INTEGRITY: next_rdata[`BIT_VALID] = backup_valid;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_out <= 8'h00;
    end else if (bus.rd && bus.cs) begin
      ad_out <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_oe <= 1'b0;
    end else begin
      ad_oe <= bus.rd && bus.cs;
    end
  end

endmodule

`default_nettype wire

// File: rtc_event_status_flags_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_flags_cfg.svh"
module rtc_flags_checker
  import rtc_flags_pkg::*;
(
  input wire logic           ref_clk,
  input wire logic           rst_n,
  input wire bus_req_t       bus,
  input wire logic [7:0]     ad_in,
  input wire logic [7:0]     ad_out,
  input wire logic           ad_oe,
  input wire event_strobes_t events,
  input wire logic           backup_valid,
  input wire logic           buffer_transfer_en,
  input wire logic [3:0]     rate_select,
  input wire logic           divider_run,
  input wire logic           irq_n
);
  logic [7:0] addr;
  logic       rd;
  logic       wr;
  assign rd = bus.rd && bus.cs;
  assign wr = bus.wr && bus.cs;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) addr <= 8'h00;
    else if (bus.ale) addr <= ad_in;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_oe_per_read: assert property (ad_oe == $past(rd)) // Read answer
    else $error("ad_oe not one cycle per read");
  chk_status_zero_bits: assert property (rd && addr == `ADDR_EVENT_STATUS |=> // Zeros
    ad_out[3] == 1'b0 && ad_out[1:0] == 2'b00) else $error("status unused bits set");
  chk_integrity_value: assert property (rd && addr == `ADDR_INTEGRITY |=> // Data
    ad_out == {$past(backup_valid), 7'h00}) else $error("integrity read wrong");
  chk_read_clears_irq: assert property (rd && addr == `ADDR_EVENT_STATUS && // Clear
    events == 3'b000 |=> irq_n) else $error("irq kept after status read");
  chk_irq_has_cause: assert property ($fell(irq_n) |-> $past(events != 3'b000 || wr))
    else $error("irq raised without cause");
  chk_osc_run_field: assert property (wr && addr == `ADDR_CTRL_A |=> // Run
    divider_run == ($past(bus.wdata[6:5]) == 2'b01)) else $error("divider_run wrong");
  chk_rate_field: assert property (wr && addr == `ADDR_CTRL_A |=> // Rate
    rate_select == $past(bus.wdata[3:0])) else $error("rate_select wrong");
  chk_inhibit_transfer: assert property (wr && addr == `ADDR_CTRL_B |=> // Inhibit
    buffer_transfer_en == !$past(bus.wdata[7])) else $error("transfer enable wrong");
  cover property (rd && addr == `ADDR_EVENT_STATUS && events != 3'b000);
  cover property ($fell(irq_n));
  cover property (wr && addr == `ADDR_CTRL_A && bus.wdata[6:4] == `OSC_RUN_UNLOCK);
endmodule
bind rtc_event_status_flags rtc_flags_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .bus(bus), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .events(events),
  .backup_valid(backup_valid), .buffer_transfer_en(buffer_transfer_en),
  .rate_select(rate_select), .divider_run(divider_run), .irq_n(irq_n));
`default_nettype wire

// File: rtc_event_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_flags_cfg.svh"
module rtc_event_status_flags_tb
  import rtc_flags_pkg::*;
;
  logic           ref_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           bv = 1'b1;
  event_strobes_t ev = '0;
  bus_req_t       bus;
  logic [7:0]     ad_in, ad_out, rdat;
  logic [3:0]     rate;
  logic           ad_oe, bte, run, irq_n, sq_out;
  int             error_cnt = 0;
  int             checks = 0;
  int             cnt;
  always #5 ref_clk = ~ref_clk;
  rtc_event_status_flags dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .ad_in(ad_in),
    .ad_out(ad_out), .ad_oe(ad_oe), .events(ev), .backup_valid(bv), .sq_rate_wave(1'b0),
    .buffer_transfer_en(bte), .rate_select(rate), .divider_run(run), .irq_n(irq_n),
    .square_wave_out(sq_out));
  rtc_host host (.ref_clk(ref_clk), .ad_out(ad_out), .ad_oe(ad_oe), .bus(bus), .ad_in(ad_in));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rdat);
    chk({8'h00, rdat}, {8'h00, e});
  endtask
  task automatic pulse(input event_strobes_t p);
    @(posedge ref_clk) ev <= p;
    @(posedge ref_clk) ev <= '0;
    @(negedge ref_clk);
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rc(`ADDR_CTRL_B, 8'h00); // Reset value
    rc(`ADDR_INTEGRITY, 8'h80); // Valid source
    @(posedge ref_clk) bv <= 1'b0;
    host.wr(`ADDR_INTEGRITY, 8'hFF);
    rc(`ADDR_INTEGRITY, 8'h00); // Depleted, write dropped
    host.wr(`ADDR_CTRL_A, 8'h25);
    chk({15'h0000, run}, 16'h0001); // Divider runs
    host.wr(`ADDR_EVENT_STATUS, 8'h74);
    rc(`ADDR_EVENT_STATUS, 8'h00); // Locked status
    pulse(3'b111);
    chk({15'h0000, irq_n}, 16'h0001); // Masked
    rc(`ADDR_EVENT_STATUS, 8'h70); // Flags set
    rc(`ADDR_EVENT_STATUS, 8'h00); // Cleared by read
    $display("test flags done");
    host.wr(`ADDR_CTRL_B, 8'h70);
    for (int i = 0; i < 3; i++) begin
      pulse(event_strobes_t'(3'b001 << i));
      chk({15'h0000, irq_n}, 16'h0000); // Request raised
      rc(`ADDR_EVENT_STATUS, 8'h80 | (8'h40 >> i)); // Request flag
      chk({15'h0000, irq_n}, 16'h0001); // Request cleared
    end
    $display("test irq done");
    host.wr(`ADDR_CTRL_B, 8'h90);
    rc(`ADDR_CTRL_B, 8'h80); // Update enable dropped
    chk({15'h0000, bte}, 16'h0000); // Transfer stopped
    pulse(3'b100);
    rc(`ADDR_EVENT_STATUS, 8'h10); // No request
    host.wr(`ADDR_CTRL_B, 8'h08);
    $display("test inhibit done");
    host.wr(`ADDR_CTRL_A, 8'h30);
    host.wr(`ADDR_EVENT_STATUS, 8'h04);
    rc(`ADDR_EVENT_STATUS, 8'h04); // Unlocked enable
    cnt = 0;
    // One full period has exactly half its samples high
    repeat (3052) @(posedge ref_clk) cnt += (sq_out === 1'b1);
    chk(16'(cnt), 16'd1526); // Fast wave
    host.wr(`ADDR_CTRL_A, 8'h20);
    rc(`ADDR_EVENT_STATUS, 8'h00); // Enable cleared
    host.wr(`ADDR_EVENT_STATUS, 8'h04);
    rc(`ADDR_EVENT_STATUS, 8'h00); // Refused under 010
    $display("test khz done");
    fork
      host.rd(`ADDR_EVENT_STATUS, rdat);
      begin
        repeat (2) @(posedge ref_clk);
        ev <= 3'b010;
        @(posedge ref_clk) ev <= '0;
      end
    join
    chk({8'h00, rdat}, 16'h0000); // Event in the read cycle not returned
    rc(`ADDR_EVENT_STATUS, 8'h20); // Event kept
    $display("test collision done");
    wrap_up();
  end
endmodule
`default_nettype wire

// File: rtc_flags_cfg.svh
`ifndef RTC_FLAGS_CFG_SVH
`define RTC_FLAGS_CFG_SVH

// Register indices on the multiplexed bus
`define ADDR_CTRL_A        8'h0A
`define ADDR_CTRL_B        8'h0B
`define ADDR_EVENT_STATUS  8'h0C
`define ADDR_INTEGRITY     8'h0D

// Control A fields
`define OSC_LSB            4
`define OSC_MSB            6
`define RATE_LSB           0
`define RATE_MSB           3
`define OSC_RUN            3'h2
`define OSC_RUN_UNLOCK     3'h3
`define CTRL_A_RESET       8'h00

// Control B fields
`define BIT_INHIBIT        7
`define BIT_PER_EN         6
`define BIT_ALM_EN         5
`define BIT_UPD_EN         4
`define BIT_SQ_EN          3
`define CTRL_B_RESET       8'h00

// Event status fields
`define BIT_IRQF           7
`define BIT_PER_FLAG       6
`define BIT_ALM_FLAG       5
`define BIT_UPD_FLAG       4
`define BIT_KHZE           2

// Integrity status
`define BIT_VALID          7

// Oscillator and timing
`define OSC_HZ             32768
`define CLK_HZ             100000000
`define OSC_HALF_CYCLES    ((`CLK_HZ + 2 * `OSC_HZ - 1) / (2 * `OSC_HZ))

`endif

// File: rtc_flags_pkg.sv
`default_nettype none
package rtc_flags_pkg;

  typedef struct packed {
    logic       ale;
    logic       cs;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic update_done;
    logic alarm_match;
    logic periodic_tick;
  } event_strobes_t;

endpackage

`default_nettype wire

// File: rtc_host.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_host
  import rtc_flags_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe,
  output var  bus_req_t   bus,
  output var  logic [7:0] ad_in
);
  initial begin
    bus = '0;
    ad_in = 8'h00;
  end
  task automatic cycle(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{1'b1, 1'b0, 1'b0, 1'b0, 8'h00};
    ad_in <= a;
    @(posedge ref_clk);
    bus <= '{1'b0, 1'b1, !w, w, d};
    // Address no longer valid once latched
    ad_in <= ~a;
    @(posedge ref_clk);
    bus <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cycle(a, 1'b1, d);
    // Written register settles before the caller looks at outputs
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cycle(a, 1'b0, 8'h00);
    @(negedge ref_clk);
    d = (ad_oe === 1'b1) ? ad_out : 8'hxx;
  endtask
endmodule
`default_nettype wire
